// file: scw_pkg.sv
// Shared constants and types of the serial configuration write receiver
package scw_pkg;

    // ****************************************
    // Sequence layout
    // ****************************************
    localparam logic [7:0] OWN_ADDR = 8'hD2;
    localparam logic [3:0] NUM_BYTES = 4'hA;
    localparam logic [3:0] KEEP_FIRST = 4'h6;
    localparam logic [3:0] KEEP_LAST = 4'h9;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;

    // ****************************************
    // Configuration carrier
    // ****************************************
    typedef struct packed {
        logic [3:0][7:0] data;
    } scw_cfg_t;

    // Data byte 4 bit 6 (24/48 MHz output active) is the only set default bit
    localparam scw_cfg_t CFG_RESET = 32'h0000_4000;

    // ****************************************
    // Receiver state
    // ****************************************
    typedef enum logic [3:0] {
        ST_IDLE   = 4'b0001,
        ST_RX     = 4'b0010,
        ST_ACK    = 4'b0100,
        ST_IGNORE = 4'b1000
    } scw_state_t;

    typedef struct packed {
        logic [1:0] scl_sync;
        logic [1:0] sda_sync;
        logic scl_d;
        logic sda_d;
        scw_state_t state;
        logic [3:0] bit_cnt;
        logic [3:0] byte_idx;
        logic [7:0] shift;
        logic oe;
        logic load;
        logic loaded;
        scw_cfg_t cfg;
    } scw_rcv_t;

endpackage : scw_pkg

// file: scw_receiver.sv
// Two-wire write-only configuration receiver with its configuration registers
`timescale 1ns/1ps

module scw_receiver #(
    parameter scw_pkg::scw_cfg_t CFG_DEFAULT = scw_pkg::CFG_RESET
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    // Serial link pins (open drain data)
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // Configuration towards the clock core
    output scw_pkg::scw_cfg_t cfg,
    output logic cfg_load
);

    scw_pkg::scw_rcv_t st_r;
    scw_pkg::scw_rcv_t st_nxt;
    logic scl_rise;
    logic scl_fall;
    logic start_cond;
    logic stop_cond;
    logic [3:0] rel_idx;

    // ****************************************
    // Slot decode
    // ****************************************
    // Slots six to nine carry data bytes 3 to 6
    function automatic logic keep_slot(input logic [3:0] idx);
        return idx >= scw_pkg::KEEP_FIRST && idx <= scw_pkg::KEEP_LAST;
    endfunction : keep_slot

    // ****************************************
    // Pin edges, seen on second sync stage only
    // ****************************************
    assign scl_rise = st_r.scl_sync[1] & ~st_r.scl_d;
    assign scl_fall = ~st_r.scl_sync[1] & st_r.scl_d;
    assign start_cond = st_r.scl_sync[1] & st_r.scl_d & st_r.sda_d & ~st_r.sda_sync[1];
    assign stop_cond = st_r.scl_sync[1] & st_r.scl_d & ~st_r.sda_d & st_r.sda_sync[1];
    assign rel_idx = st_r.byte_idx - scw_pkg::KEEP_FIRST;

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        st_nxt = st_r;
        st_nxt.scl_sync = {st_r.scl_sync[0], scl_in};
        st_nxt.sda_sync = {st_r.sda_sync[0], sda_in};
        st_nxt.scl_d = st_r.scl_sync[1];
        st_nxt.sda_d = st_r.sda_sync[1];
        st_nxt.load = 1'b0;
        if (start_cond) begin
            // Repeated start restarts the byte count from the address
            st_nxt.state = scw_pkg::ST_RX;
            st_nxt.bit_cnt = '0;
            st_nxt.byte_idx = '0;
            st_nxt.oe = 1'b0;
        end else if (stop_cond) begin
            st_nxt.state = scw_pkg::ST_IDLE;
            st_nxt.oe = 1'b0;
        end else begin
            unique case (st_r.state)
                scw_pkg::ST_IDLE: begin
                    st_nxt.oe = 1'b0;
                end
                scw_pkg::ST_RX: begin
                    if (scl_rise && st_r.bit_cnt < scw_pkg::BITS_PER_BYTE) begin
                        st_nxt.shift = {st_r.shift[6:0], st_r.sda_sync[1]};
                        st_nxt.bit_cnt = st_r.bit_cnt + 4'h1;
                    end else if (scl_fall && st_r.bit_cnt == scw_pkg::BITS_PER_BYTE) begin
                        if (st_r.byte_idx == '0 && st_r.shift != scw_pkg::OWN_ADDR) begin
                            // Read address or foreign device: stay off the bus
                            st_nxt.state = scw_pkg::ST_IGNORE;
                        end else if (st_r.byte_idx >= scw_pkg::NUM_BYTES) begin
                            // Bytes beyond the tenth are not acknowledged
                            st_nxt.state = scw_pkg::ST_IGNORE;
                        end else begin
                            st_nxt.state = scw_pkg::ST_ACK;
                            st_nxt.oe = 1'b1;
                            if (keep_slot(st_r.byte_idx)) begin
                                st_nxt.cfg.data[rel_idx[1:0]] = st_r.shift;
                                st_nxt.loaded = 1'b1;
                                st_nxt.load = (st_r.byte_idx == scw_pkg::KEEP_LAST);
                            end
                            // Command and count bytes only advance the slot
                        end
                    end
                end
                scw_pkg::ST_ACK: begin
                    if (scl_fall) begin
                        st_nxt.state = scw_pkg::ST_RX;
                        st_nxt.oe = 1'b0;
                        st_nxt.bit_cnt = '0;
                        st_nxt.byte_idx = st_r.byte_idx + 4'h1;
                    end
                end
                scw_pkg::ST_IGNORE: begin
                    st_nxt.oe = 1'b0;
                end
                default: begin
                    st_nxt.state = scw_pkg::ST_IDLE;
                    st_nxt.oe = 1'b0;
                end
            endcase
        end
    end

    // ****************************************
    // State register
    // ****************************************
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            st_r.scl_sync <= 2'h3;
            st_r.sda_sync <= 2'h3;
            st_r.scl_d <= 1'b1;
            st_r.sda_d <= 1'b1;
            st_r.state <= scw_pkg::ST_IDLE;
            st_r.bit_cnt <= '0;
            st_r.byte_idx <= '0;
            st_r.shift <= '0;
            st_r.oe <= 1'b0;
            st_r.load <= 1'b0;
            st_r.loaded <= 1'b0;
            st_r.cfg <= CFG_DEFAULT;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Only ever pulls low; the pin is released otherwise
    assign sda_out = 1'b0;
    assign sda_oe = st_r.oe;
    assign cfg = st_r.cfg;
    assign cfg_load = st_r.load;

    // ****************************************
    // Checks
    // ****************************************
    sequence s_addr_done;
        st_r.state == scw_pkg::ST_RX && scl_fall && st_r.bit_cnt == scw_pkg::BITS_PER_BYTE && st_r.byte_idx == '0;
    endsequence

    sequence s_ack_begun;
        st_r.state == scw_pkg::ST_ACK && st_r.oe;
    endsequence

    sequence s_ack_ending;
        st_r.state == scw_pkg::ST_ACK && scl_fall && !start_cond && !stop_cond;
    endsequence

    AST_ADDR_MATCH_ACKED: assert property (@(posedge clk_sys) disable iff (!resetn)
        s_addr_done and (st_r.shift == scw_pkg::OWN_ADDR) and !start_cond and !stop_cond |=> s_ack_begun)
        else $error("Matching address not acknowledged");

    AST_ADDR_MISMATCH_NACK: assert property (@(posedge clk_sys) disable iff (!resetn)
        s_addr_done and (st_r.shift != scw_pkg::OWN_ADDR) |=> !sda_oe)
        else $error("Foreign address acknowledged");

    AST_FOREIGN_NO_WRITE: assert property (@(posedge clk_sys) disable iff (!resetn)
        st_r.state == scw_pkg::ST_IGNORE |=> $stable(cfg))
        else $error("Configuration changed during ignored transfer");

    AST_EARLY_BYTES_DROPPED: assert property (@(posedge clk_sys) disable iff (!resetn)
        st_r.byte_idx < scw_pkg::KEEP_FIRST |=> $stable(cfg))
        else $error("Configuration changed before data byte 3");

    AST_LOAD_SLOT: assert property (@(posedge clk_sys) disable iff (!resetn)
        !$stable(cfg) |-> keep_slot($past(st_r.byte_idx)))
        else $error("Configuration loaded outside data bytes 3 to 6");

    AST_LOAD_LAST: assert property (@(posedge clk_sys) disable iff (!resetn)
        cfg_load |-> cfg.data[3] == $past(st_r.shift) && st_r.byte_idx == scw_pkg::KEEP_LAST)
        else $error("Final load pulse mismatched");

    AST_MSB_FIRST: assert property (@(posedge clk_sys) disable iff (!resetn)
        st_r.state == scw_pkg::ST_RX && scl_rise && st_r.bit_cnt < scw_pkg::BITS_PER_BYTE && !start_cond && !stop_cond
        |=> st_r.shift[0] == $past(st_r.sda_sync[1]) && st_r.shift[7:1] == $past(st_r.shift[6:0]))
        else $error("Bit not shifted in order");

    AST_DRIVE_ONLY_ACK: assert property (@(posedge clk_sys) disable iff (!resetn)
        sda_oe |-> st_r.state == scw_pkg::ST_ACK)
        else $error("Data pin driven outside acknowledge");

    AST_DEFAULT_HELD: assert property (@(posedge clk_sys) disable iff (!resetn)
        !st_r.loaded |-> cfg == CFG_DEFAULT)
        else $error("Configuration left default without a write");

    AST_BYTE_LIMIT: assert property (@(posedge clk_sys) disable iff (!resetn)
        st_r.byte_idx <= scw_pkg::NUM_BYTES)
        else $error("Byte slot beyond ten");

    AST_ACK_RELEASED: assert property (@(posedge clk_sys) disable iff (!resetn)
        s_ack_ending |=> !sda_oe && st_r.state == scw_pkg::ST_RX)
        else $error("Acknowledge held past the ninth clock");

    AST_SLOT_ADVANCE: assert property (@(posedge clk_sys) disable iff (!resetn)
        s_ack_ending |=> st_r.byte_idx == $past(st_r.byte_idx) + 4'h1)
        else $error("Byte slot did not advance by one");

    AST_START_RESTARTS: assert property (@(posedge clk_sys) disable iff (!resetn)
        start_cond |=> st_r.state == scw_pkg::ST_RX && st_r.byte_idx == 4'h0 && !sda_oe)
        else $error("Start did not restart at the address byte");

    AST_LOAD_ONE_CYCLE: assert property (@(posedge clk_sys) disable iff (!resetn)
        cfg_load |=> !cfg_load)
        else $error("Load pulse longer than one cycle");

    AST_IGNORE_SILENT: assert property (@(posedge clk_sys) disable iff (!resetn)
        st_r.state == scw_pkg::ST_IGNORE |-> !sda_oe && !cfg_load)
        else $error("Ignored transfer drove the bus or loaded");

endmodule : scw_receiver

// file: scw_master.sv
// Behavioural two-wire bus master that writes configuration sequences
`timescale 1ns/1ps
module scw_master (
    // Bus wires
    output logic scl,
    output logic sda_m,
    input wire logic sda_line
);
    // Both wires idle high (pull-up) until a frame starts
    initial begin
        scl <= 1'b1;
        sda_m <= 1'b1;
    end
    // Edges land on system clock edges; NBA keeps the receiver's sampling order fixed
    task automatic start_cond();
        sda_m <= 1'b0;
        #40 scl <= 1'b0;
    endtask : start_cond
    // Repeated start: release data, raise the clock, then pull data low
    task automatic restart_cond();
        #20 sda_m <= 1'b1;
        #20 scl <= 1'b1;
        #40 start_cond();
    endtask : restart_cond
    task automatic stop_cond();
        #20 sda_m <= 1'b0;
        #20 scl <= 1'b1;
        #40 sda_m <= 1'b1;
        #80;
    endtask : stop_cond
    // Data only moves while the clock is low
    task automatic put_byte(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            #20 sda_m <= b[i];
            #20 scl <= 1'b1;
            #40 scl <= 1'b0;
        end
        #20 sda_m <= 1'b1;
        #20 scl <= 1'b1;
        #20 ack = !sda_line;
        #20 scl <= 1'b0;
    endtask : put_byte
    task automatic send(input logic [7:0] seq [10], output logic [9:0] acks);
        start_cond();
        for (int k = 0; k < 10; k++) begin
            put_byte(seq[k], acks[k]);
        end
        stop_cond();
    endtask : send
endmodule : scw_master

// file: scw_receiver_test.sv
// Self-checking bench of the configuration write receiver
`timescale 1ns/1ps
module scw_receiver_test;
    logic clk_sys;
    logic resetn;
    logic scl;
    logic sda_m;
    logic sda_line;
    logic sda_out;
    logic sda_oe;
    scw_pkg::scw_cfg_t cfg;
    logic cfg_load;
    logic [9:0] acks;
    logic [7:0] seq [10];
    int bad_count = 0;
    int check_count = 0;
    int load_count = 0;
    // ****************************************
    // Wiring
    // ****************************************
    // Open drain: either party pulling low wins
    assign sda_line = sda_m & !(sda_oe && !sda_out);
    scw_receiver dut (.clk_sys(clk_sys), .resetn(resetn), .scl_in(scl), .sda_in(sda_line),
        .sda_out(sda_out), .sda_oe(sda_oe), .cfg(cfg), .cfg_load(cfg_load));
    scw_master master (.scl(scl), .sda_m(sda_m), .sda_line(sda_line));
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        if (cfg_load === 1'b1) load_count++;
    end
    // ****************************************
    // Checking and verdict
    // ****************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic final_report();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : final_report
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic test_reset();
        check(cfg, scw_pkg::CFG_RESET);
        check({31'h0, sda_oe}, 32'h0000_0000);
        check({31'h0, cfg_load}, 32'h0000_0000);
        check({31'h0, sda_out}, 32'h0000_0000);
    endtask : test_reset
    // Byte count of one must not cut the frame short; data bytes 0-2 all ones must not leak
    task automatic test_good_write();
        int l0;
        l0 = load_count;
        seq = '{8'hD2, 8'hA5, 8'h01, 8'hFF, 8'hFF, 8'hFF, 8'h12, 8'h43, 8'h56, 8'h78};
        master.send(seq, acks);
        check({22'h0, acks}, 32'h0000_03FF);
        check(cfg, 32'h7856_4312);
        check(load_count - l0, 32'h0000_0001);
    endtask : test_good_write
    // Near-miss addresses, the read form among them, must leave everything alone
    task automatic test_foreign();
        logic [7:0] addrs [3];
        int l0;
        addrs = '{8'hD3, 8'hD0, 8'h52};
        for (int a = 0; a < 3; a++) begin
            seq = '{addrs[a], 8'h00, 8'h07, 8'h00, 8'h00, 8'h00, 8'h01, 8'h02, 8'h03, 8'h04};
            l0 = load_count;
            master.send(seq, acks);
            check({22'h0, acks}, 32'h0000_0000);
            check(cfg, 32'h7856_4312);
            check(load_count - l0, 32'h0000_0000);
        end
    endtask : test_foreign
    // An eleventh byte is refused and leaves the ten already taken alone
    task automatic test_long_write();
        logic ack;
        int l0;
        l0 = load_count;
        seq = '{8'hD2, 8'h00, 8'h07, 8'h00, 8'h00, 8'h00, 8'h71, 8'h07, 8'h9A, 8'hBC};
        acks = '0;
        master.start_cond();
        for (int k = 0; k < 10; k++) begin
            master.put_byte(seq[k], acks[k]);
        end
        master.put_byte(8'hEE, ack);
        master.stop_cond();
        check({22'h0, acks}, 32'h0000_03FF);
        check({31'h0, ack}, 32'h0000_0000);
        check(cfg, 32'hBC9A_0771);
        check(load_count - l0, 32'h0000_0001);
    endtask : test_long_write
    // Repeated start after data byte 3: that byte stays, the foreign address after it loads nothing
    task automatic test_restart();
        logic ack;
        int l0;
        l0 = load_count;
        seq = '{8'hD2, 8'h00, 8'h07, 8'h00, 8'h00, 8'h00, 8'h31, 8'h00, 8'h00, 8'h00};
        acks = '0;
        master.start_cond();
        for (int k = 0; k < 7; k++) begin
            master.put_byte(seq[k], acks[k]);
        end
        master.restart_cond();
        master.put_byte(8'hD3, ack);
        master.stop_cond();
        check({22'h0, acks}, 32'h0000_007F);
        check({31'h0, ack}, 32'h0000_0000);
        check(cfg, 32'hBC9A_0731);
        check(load_count - l0, 32'h0000_0000);
    endtask : test_restart
    // ****************************************
    // Main sequence and watchdog
    // ****************************************
    initial begin
        resetn = 1'b0;
        repeat (12) @(posedge clk_sys);
        resetn <= 1'b1;
        repeat (6) @(posedge clk_sys);
        test_reset();
        test_good_write();
        test_foreign();
        test_long_write();
        test_restart();
        final_report();
    end
    // Six frames take about 40 us; allow several times that
    initial begin
        #300_000;
        bad_count++;
        final_report();
    end
endmodule : scw_receiver_test
